/* core/apoc_ctl.sv */
// module: status/alarm pins, output enables and calibration gating of the clock multiplier
`timescale 1ns/100ps

module apoc_ctl
   import apoc_pkg::*;
#(
   parameter int NUM_IN  = APOC_NUM_INPUTS,
   parameter int NUM_OUT = APOC_NUM_OUTPUTS
) (
   // clock and reset
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst,
   input  wire logic                i_hw_rst_n,
   // register port
   input  wire apoc_reg_req_s       i_reg,
   output logic [7:0]               o_rd_data,
   output logic                     o_rd_valid,
   // calibration core
   output logic                     o_cal_start,
   input  wire logic                i_cal_done,
   input  wire logic                i_lock_loss,
   // output control
   output logic [NUM_OUT-1:0]       o_clk_out_en,
   output logic                     o_skew_preserve,
   output logic signed [7:0]        o_skew5_offset,
   output logic                     o_skew5_valid,
   // alarm sources
   input  wire logic [NUM_IN-1:0]   i_input_bad,
   input  wire logic                i_irq_req,
   input  wire logic                i_summary_alarm,
   // pins
   output logic [NUM_IN-1:0]        o_inv_pin,
   output logic [NUM_IN-1:0]        o_inv_pin_oe,
   output logic                     o_interrupt_alarm_pin_pin,
   output logic                     o_interrupt_alarm_pin_pin_oe
);

   // ************************************************************
   // hardware reset pin synchroniser
   // ************************************************************
   logic [2:0] rst_sync;
   logic       hw_rst;
   logic       next_hw_rst;

   always_comb begin
      next_hw_rst = hw_rst;
      if (rst_sync[1] == rst_sync[2]) begin
         next_hw_rst = ~rst_sync[2];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rst_sync <= 3'h0;
         hw_rst   <= 1'b1;
      end else begin
         rst_sync <= {rst_sync[1:0], i_hw_rst_n};
         hw_rst   <= next_hw_rst;
      end
   end

   // ************************************************************
   // registers and calibration state
   // ************************************************************
   apoc_cal_cfg_s cfg;
   apoc_cal_cfg_s next_cfg;
   apoc_pins_s    pins;
   apoc_pins_s    next_pins;
   logic [7:0]    skew5;
   logic [7:0]    next_skew5;
   logic          cal_start;
   logic          next_cal_start;
   logic          cal_busy;
   logic          next_cal_busy;
   logic          first_cal;
   logic          next_first_cal;
   logic          good_cal;
   logic          next_good_cal;
   logic          recal;
   logic          next_recal;
   logic [7:0]    rd_data;
   logic [7:0]    next_rd_data;
   logic          rd_valid;
   logic          next_rd_valid;
   logic [7:0]    stat_byte;
   logic          cal_addr_hit;

   always_comb begin
      stat_byte                      = APOC_ZERO_BYTE;
      stat_byte[APOC_STAT_FIRST_CAL] = first_cal;
      stat_byte[APOC_STAT_GOOD_CAL]  = good_cal;
      stat_byte[APOC_STAT_RECAL]     = recal;
      stat_byte[APOC_STAT_LOCK_LOSS] = i_lock_loss;
      stat_byte[APOC_STAT_CAL_BUSY]  = cal_busy;
      cal_addr_hit = i_reg.wr && (i_reg.addr <= APOC_CAL_LAST);
   end

   always_comb begin
      next_cfg       = cfg;
      next_pins      = pins;
      next_skew5     = skew5;
      next_cal_start = 1'b0;
      next_cal_busy  = cal_busy;
      next_first_cal = first_cal;
      next_good_cal  = good_cal;
      next_recal     = recal;
      next_rd_data   = rd_data;
      next_rd_valid  = 1'b0;
      if (i_reg.wr) begin
         case (i_reg.addr)
            APOC_REG_CTRL: begin
               next_cfg.always_on = i_reg.data[APOC_CTRL_ALWAYS_ON];
            end
            APOC_REG_CAL: begin
               next_cfg.skew_pres = i_reg.data[APOC_CAL_SKEW_PRES];
               next_cfg.out_cfg   = i_reg.data[APOC_CAL_OUT_CFG];
               next_cal_start     = i_reg.data[APOC_CAL_TRIGGER];
            end
            APOC_REG_PINS: begin
               next_pins.inv_en  = i_reg.data[APOC_PIN_INV_EN_LO +: NUM_IN];
               next_pins.inv_pol = i_reg.data[APOC_PIN_INV_POL];
               next_pins.int_en  = i_reg.data[APOC_PIN_INT_EN];
               next_pins.interrupt_polarity = i_reg.data[APOC_PIN_INTERRUPT_POLARITY];
               next_pins.alm_en  = i_reg.data[APOC_PIN_ALM_EN];
            end
            APOC_REG_SKEW5: begin
               next_skew5 = i_reg.data;
            end
            default: begin
               next_skew5 = skew5;
            end
         endcase
      end
      if (i_reg.rd) begin
         next_rd_valid = 1'b1;
         case (i_reg.addr)
            APOC_REG_CTRL: begin
               next_rd_data                      = APOC_ZERO_BYTE;
               next_rd_data[APOC_CTRL_ALWAYS_ON] = cfg.always_on;
            end
            APOC_REG_CAL: begin
               next_rd_data                     = APOC_ZERO_BYTE;
               next_rd_data[APOC_CAL_SKEW_PRES] = cfg.skew_pres;
               next_rd_data[APOC_CAL_OUT_CFG]   = cfg.out_cfg;
            end
            APOC_REG_PINS: begin
               next_rd_data                                 = APOC_ZERO_BYTE;
               next_rd_data[APOC_PIN_INV_EN_LO +: NUM_IN]   = pins.inv_en;
               next_rd_data[APOC_PIN_INV_POL]               = pins.inv_pol;
               next_rd_data[APOC_PIN_INT_EN]                = pins.int_en;
               next_rd_data[APOC_PIN_INTERRUPT_POLARITY]               = pins.interrupt_polarity;
               next_rd_data[APOC_PIN_ALM_EN]                = pins.alm_en;
            end
            APOC_REG_STAT: begin
               next_rd_data = stat_byte;
            end
            APOC_REG_SKEW5: begin
               next_rd_data = skew5;
            end
            default: begin
               next_rd_data = APOC_ZERO_BYTE;
            end
         endcase
      end
      // calibration progress
      if (i_cal_done && cal_busy) begin
         next_cal_busy  = 1'b0;
         next_first_cal = 1'b1;
      end
      if (cal_start) begin
         next_cal_busy = 1'b1;
         next_recal    = 1'b0;
      end
      if (first_cal && !cal_busy && !i_lock_loss) begin
         next_good_cal = 1'b1;
      end
      // a configuration write in the calibration range beats the clear
      if (cal_addr_hit) begin
         next_recal = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg       <= '0;
         pins      <= '0;
         skew5     <= APOC_SKEW5_RST;
         cal_start <= 1'b0;
         cal_busy  <= 1'b0;
         first_cal <= 1'b0;
         good_cal  <= 1'b0;
         recal     <= 1'b0;
         rd_data   <= APOC_ZERO_BYTE;
         rd_valid  <= 1'b0;
      end else if (hw_rst) begin
         cfg       <= '0;
         pins      <= '0;
         skew5     <= APOC_SKEW5_RST;
         cal_start <= 1'b0;
         cal_busy  <= 1'b0;
         first_cal <= 1'b0;
         good_cal  <= 1'b0;
         recal     <= 1'b0;
         rd_data   <= APOC_ZERO_BYTE;
         rd_valid  <= 1'b0;
      end else begin
         cfg       <= next_cfg;
         pins      <= next_pins;
         skew5     <= next_skew5;
         cal_start <= next_cal_start;
         cal_busy  <= next_cal_busy;
         first_cal <= next_first_cal;
         good_cal  <= next_good_cal;
         recal     <= next_recal;
         rd_data   <= next_rd_data;
         rd_valid  <= next_rd_valid;
      end
   end

   // ************************************************************
   // output gating and pins
   // ************************************************************
   logic               next_out_on;
   logic               out_on;
   logic [NUM_IN-1:0]  next_inv_pin;
   logic [NUM_IN-1:0]  inv_pin;
   logic               next_int_pin;
   logic               int_pin;
   logic               next_int_oe;
   logic               int_oe;

   always_comb begin
      if (cfg.always_on) begin
         next_out_on = 1'b1;
      end else if (cfg.skew_pres) begin
         next_out_on = good_cal;
      end else begin
         next_out_on = first_cal;
      end
      if (hw_rst) begin
         next_out_on = 1'b0;
      end
      next_inv_pin = pins.inv_pol ? i_input_bad : ~i_input_bad;
      if (pins.int_en) begin
         next_int_pin = pins.interrupt_polarity ? i_irq_req : ~i_irq_req;
         next_int_oe  = 1'b1;
      end else if (pins.alm_en) begin
         next_int_pin = pins.inv_pol ? i_summary_alarm : ~i_summary_alarm;
         next_int_oe  = 1'b1;
      end else begin
         next_int_pin = 1'b0;
         next_int_oe  = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         out_on  <= 1'b0;
         inv_pin <= '0;
         int_pin <= 1'b0;
         int_oe  <= 1'b0;
      end else begin
         out_on  <= next_out_on;
         inv_pin <= next_inv_pin;
         int_pin <= next_int_pin;
         int_oe  <= next_int_oe;
      end
   end

   assign o_clk_out_en     = {NUM_OUT{out_on}};
   assign o_skew_preserve  = cfg.skew_pres;
   assign o_skew5_offset   = skew5;
   assign o_skew5_valid    = ~cfg.out_cfg;
   assign o_inv_pin        = inv_pin;
   assign o_inv_pin_oe     = pins.inv_en;
   assign o_interrupt_alarm_pin_pin    = int_pin;
   assign o_interrupt_alarm_pin_pin_oe = int_oe;
   assign o_cal_start      = cal_start;
   assign o_rd_data        = rd_data;
   assign o_rd_valid       = rd_valid;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   sequence s_cal_done;
      cal_busy && i_cal_done && !hw_rst;
   endsequence
   sequence s_off_mode2;
      !cfg.always_on && !cfg.skew_pres && !hw_rst;
   endsequence

   AST_SKEW5_VALID: assert property (o_skew5_valid == !cfg.out_cfg && o_skew5_offset == skew5)
      else $error("skew5 offset or valid wrong");
   AST_OFF_BEFORE_CAL: assert property (!first_cal && !cfg.always_on |=> !o_clk_out_en[0])
      else $error("outputs on before first calibration");
   AST_ON_AFTER_CAL: assert property (s_cal_done ##1 s_off_mode2 |=> o_clk_out_en[0])
      else $error("outputs not on after first calibration");
   AST_GOOD_NEEDS_LOCK: assert property (!good_cal && cfg.skew_pres && !cfg.always_on |=> !o_clk_out_en[0])
      else $error("outputs on before good calibration");
   AST_ALWAYS_ON: assert property (cfg.always_on && !hw_rst |=> o_clk_out_en == {NUM_OUT{1'b1}})
      else $error("outputs off with always-on set");
   AST_RECAL_SET: assert property (cal_addr_hit && !hw_rst |=> recal)
      else $error("recal flag not set by config write");
   AST_HW_RESET: assert property (hw_rst |=> skew5 == APOC_SKEW5_RST && !first_cal)
      else $error("hardware reset did not clear state");
   AST_RESET_OUT_OFF: assert property (hw_rst |=> o_clk_out_en == '0)
      else $error("outputs on during reset");
   AST_INV_OE: assert property (o_inv_pin_oe == pins.inv_en)
      else $error("invalid pin enable wrong");
   AST_INV_POL: assert property (!i_rst |=> o_inv_pin == ($past(pins.inv_pol) ? $past(i_input_bad) : ~$past(i_input_bad)))
      else $error("invalid pin level wrong");
   AST_INT_PIN: assert property (pins.int_en |=> o_interrupt_alarm_pin_pin_oe && o_interrupt_alarm_pin_pin == ($past(i_irq_req) ~^ $past(pins.interrupt_polarity)))
      else $error("interrupt pin wrong");
   AST_ALM_PIN: assert property (!pins.int_en && pins.alm_en |=> o_interrupt_alarm_pin_pin_oe && o_interrupt_alarm_pin_pin == ($past(i_summary_alarm) ~^ $past(pins.inv_pol)))
      else $error("alarm pin wrong");
   AST_TRISTATE: assert property (!pins.int_en && !pins.alm_en |=> !o_interrupt_alarm_pin_pin_oe)
      else $error("shared pin not tristated");

endmodule

/* pkg/apoc_pkg.sv */
// package: register map, field positions and carrier types of the alarm/calibration control
package apoc_pkg;

   // ************************************************************
   // register offsets (byte addresses of the serial register port)
   // ************************************************************
   localparam logic [7:0] APOC_REG_CTRL   = 8'h00;
   localparam logic [7:0] APOC_REG_CAL    = 8'h88;
   localparam logic [7:0] APOC_REG_PINS   = 8'h89;
   localparam logic [7:0] APOC_REG_STAT   = 8'h8A;
   localparam logic [7:0] APOC_REG_SKEW5  = 8'h90;
   localparam logic [7:0] APOC_CAL_LAST   = 8'h38;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int APOC_CTRL_ALWAYS_ON  = 0;
   localparam int APOC_CAL_SKEW_PRES   = 0;
   localparam int APOC_CAL_TRIGGER     = 1;
   localparam int APOC_CAL_OUT_CFG     = 2;
   localparam int APOC_PIN_INV_EN_LO   = 0;
   localparam int APOC_PIN_INV_POL     = 3;
   localparam int APOC_PIN_INT_EN      = 4;
   localparam int APOC_PIN_INTERRUPT_POLARITY     = 5;
   localparam int APOC_PIN_ALM_EN      = 6;
   localparam int APOC_STAT_FIRST_CAL  = 0;
   localparam int APOC_STAT_GOOD_CAL   = 1;
   localparam int APOC_STAT_RECAL      = 2;
   localparam int APOC_STAT_LOCK_LOSS  = 3;
   localparam int APOC_STAT_CAL_BUSY   = 4;

   // ************************************************************
   // widths and reset values
   // ************************************************************
   localparam int          APOC_NUM_INPUTS  = 3;
   localparam int          APOC_NUM_OUTPUTS = 5;
   localparam logic [7:0]  APOC_SKEW5_RST   = 8'h00;
   localparam logic [7:0]  APOC_ZERO_BYTE   = 8'h00;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic [APOC_NUM_INPUTS-1:0] inv_en;
      logic                       inv_pol;
      logic                       int_en;
      logic                       interrupt_polarity;
      logic                       alm_en;
   } apoc_pins_s;

   typedef struct packed {
      logic always_on;
      logic skew_pres;
      logic out_cfg;
   } apoc_cal_cfg_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] data;
   } apoc_reg_req_s;

endpackage

/* tb/apoc_board.sv */
// partner: calibration core and board controller watching the alarm pins
`timescale 1ns/100ps
module apoc_board
   import apoc_pkg::*;
(
   // clock
   input  wire logic                       i_sys_clk,
   // calibration core
   input  wire logic                       i_cal_start,
   input  wire logic                       i_slow,
   output logic                            o_cal_done,
   // pins and the lines the board sees
   input  wire logic [APOC_NUM_INPUTS-1:0] i_inv_pin,
   input  wire logic [APOC_NUM_INPUTS-1:0] i_inv_pin_oe,
   input  wire logic                       i_interrupt_alarm_pin_pin,
   input  wire logic                       i_interrupt_alarm_pin_pin_oe,
   output logic [APOC_NUM_INPUTS-1:0]      o_inv_line,
   output logic                            o_interrupt_alarm_pin_line
);
   logic [3:0]                 cnt      = 4'h0;
   logic [APOC_NUM_INPUTS-1:0] inv_last = 3'h0;
   logic                       int_last = 1'b0;
   initial o_cal_done = 1'b0;
   // ************************************************************
   // calibration core: answers promptly or slowly
   // ************************************************************
   always @(posedge i_sys_clk) begin
      o_cal_done <= (cnt == 4'h1);
      if (i_cal_start)
         cnt <= i_slow ? 4'hC : 4'h2;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
   end
   // ************************************************************
   // released lines show the inverse of the last driven level
   // ************************************************************
   always @(posedge i_sys_clk) begin
      inv_last <= (i_inv_pin & i_inv_pin_oe) | (inv_last & ~i_inv_pin_oe);
      int_last <= i_interrupt_alarm_pin_pin_oe ? i_interrupt_alarm_pin_pin : int_last;
   end
   assign o_inv_line     = (i_inv_pin & i_inv_pin_oe) | (~inv_last & ~i_inv_pin_oe);
   assign o_interrupt_alarm_pin_line = i_interrupt_alarm_pin_pin_oe ? i_interrupt_alarm_pin_pin : ~int_last;
endmodule

/* tb/apoc_ctl_bench.sv */
// testbench: register port, calibration gating and alarm pins
`timescale 1ns/100ps
module apoc_ctl_bench
   import apoc_pkg::*;
;
   logic              clk = 1'b0, rst = 1'b1, hw_rst_n = 1'b1, lock_loss = 1'b1;
   logic              irq = 1'b0, alarm = 1'b0, slow = 1'b0;
   logic [2:0]        input_bad = 3'h0;
   apoc_reg_req_s     req = '0;
   logic [7:0]        rd_data, rnd = 8'h0C, cfg;
   logic              rd_valid, cal_start, cal_done, skew_pres, skew5_valid;
   logic signed [7:0] skew5;
   logic [4:0]        clk_en;
   logic [2:0]        inv_pin, inv_oe, inv_line, bad;
   logic              int_pin, int_oe, int_line, pol, ie, ip, ae;
   logic [7:0]        exp_q[$];
   int                mismatches = 0, total_checks = 0;

   always #20 clk = ~clk;

   apoc_ctl apoc_ctl_i (.i_sys_clk(clk), .i_rst(rst), .i_hw_rst_n(hw_rst_n), .i_reg(req),
      .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_cal_start(cal_start),
      .i_cal_done(cal_done), .i_lock_loss(lock_loss), .o_clk_out_en(clk_en),
      .o_skew_preserve(skew_pres), .o_skew5_offset(skew5), .o_skew5_valid(skew5_valid),
      .i_input_bad(input_bad), .i_irq_req(irq), .i_summary_alarm(alarm),
      .o_inv_pin(inv_pin), .o_inv_pin_oe(inv_oe), .o_interrupt_alarm_pin_pin(int_pin),
      .o_interrupt_alarm_pin_pin_oe(int_oe));
   apoc_board apoc_board_i (.i_sys_clk(clk), .i_cal_start(cal_start), .i_slow(slow),
      .o_cal_done(cal_done), .i_inv_pin(inv_pin), .i_inv_pin_oe(inv_oe),
      .i_interrupt_alarm_pin_pin(int_pin), .i_interrupt_alarm_pin_pin_oe(int_oe), .o_inv_line(inv_line),
      .o_interrupt_alarm_pin_line(int_line));

   // ************************************************************
   // shared tasks
   // ************************************************************
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
      total_checks++;
      if (seen !== expv || $isunknown(seen)) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask
   task automatic stop_test();
      chk(8'(exp_q.size()), 8'h00);
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      exp_q.push_back(e);
      @(posedge clk);
      req <= '0;
   endtask
   task automatic wait_en(input logic [4:0] e);
      int k;
      #1;
      for (k = 0; k < 40 && clk_en !== e; k++)
         cyc(1);
      chk({3'h0, clk_en}, {3'h0, e});
      if (clk_en !== e)
         stop_test();
   endtask
   task automatic hw_reset();
      @(posedge clk);
      hw_rst_n <= 1'b0;
      cyc(5);
      chk({3'h0, clk_en}, 8'h00);
      wr(APOC_REG_SKEW5, 8'h5A);
      @(posedge clk);
      hw_rst_n <= 1'b1;
      cyc(6);
      rd(APOC_REG_SKEW5, APOC_SKEW5_RST);
   endtask

   // ************************************************************
   // read results are compared against the oldest note
   // ************************************************************
   always @(posedge clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0)
            chk(rd_data, 8'hXX);
         else
            chk(rd_data, exp_q.pop_front());
      end
   end

   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      stop_test();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      cyc(6);
      chk({3'h0, clk_en}, 8'h00);
      chk({7'h0, skew5_valid}, 8'h01);
      rd(APOC_REG_SKEW5, APOC_SKEW5_RST);
      rd(8'h39, APOC_ZERO_BYTE);
      rd(APOC_REG_STAT, 8'h08);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         wr(APOC_REG_SKEW5, rnd);
         rd(APOC_REG_SKEW5, rnd);
         cyc(1);
         chk(skew5, rnd);
      end
      wr(APOC_REG_CAL, 8'h04);
      cyc(2);
      chk({7'h0, skew5_valid}, 8'h00);
      wr(APOC_REG_CAL, 8'h00);
      cyc(2);
      chk({7'h0, skew5_valid}, 8'h01);
      $display("test skew done");
      for (int m = 0; m < 4; m++) begin
         hw_reset();
         lock_loss <= 1'b1;
         slow <= m[1];
         wr(APOC_REG_CTRL, {7'h0, m[1]});
         wr(APOC_REG_CAL, {7'h0, m[0]});
         cyc(3);
         chk({3'h0, clk_en}, {3'h0, {5{m[1]}}});
         chk({7'h0, skew_pres}, {7'h0, m[0]});
         rd(APOC_REG_STAT, 8'h0C);
         wr(APOC_REG_CAL, {6'h0, 1'b1, m[0]});
         cyc(4);
         if (m[1])
            chk({3'h0, clk_en}, 8'h1F);
         cyc(16);
         if (m == 1)
            chk({3'h0, clk_en}, 8'h00);
         else
            wait_en(5'h1F);
         rd(APOC_REG_STAT, 8'h09);
         lock_loss <= 1'b0;
         wait_en(5'h1F);
         rd(APOC_REG_STAT, 8'h03);
      end
      wr(8'h39, 8'hFF);
      rd(APOC_REG_STAT, 8'h03);
      wr(APOC_CAL_LAST, 8'h00);
      rd(APOC_REG_STAT, 8'h07);
      $display("test calibration done");
      for (int k = 0; k < 24; k++) begin
         rnd = lfsr(rnd);
         cfg = {1'b0, rnd[6:0]};
         wr(APOC_REG_PINS, cfg);
         rnd = lfsr(rnd);
         bad = rnd[2:0];
         input_bad <= bad;
         irq <= rnd[3];
         alarm <= rnd[4];
         pol = cfg[APOC_PIN_INV_POL];
         ie = cfg[APOC_PIN_INT_EN];
         ip = cfg[APOC_PIN_INTERRUPT_POLARITY];
         ae = cfg[APOC_PIN_ALM_EN];
         cyc(3);
         rd(APOC_REG_PINS, cfg);
         chk({5'h0, inv_oe}, {5'h0, cfg[2:0]});
         chk({5'h0, inv_line & cfg[2:0]}, {5'h0, (pol ? bad : ~bad) & cfg[2:0]});
         chk({7'h0, int_oe}, {7'h0, ie | ae});
         if (ie | ae)
            chk({7'h0, int_line}, {7'h0, ie ? ~(ip ^ rnd[3]) : ~(pol ^ rnd[4])});
      end
      $display("test pins done");
      cyc(4);
      stop_test();
   end
endmodule
